// *** include/rmsc_cfg.svh ***
`ifndef RMSC_CFG_SVH
`define RMSC_CFG_SVH

`define RMSC_ADDR_W         6
`define RMSC_OFS_FREQ_DEV   6'h15
`define RMSC_OFS_SM_TWO     6'h16
`define RMSC_OFS_SM_ONE     6'h17
`define RMSC_OFS_SM_ZERO    6'h18

`define RMSC_DEV_EXP_F      6:4
`define RMSC_DEV_MANT_F     2:0
`define RMSC_RX_END_BIT     4
`define RMSC_SM2_LOW_F      3:0
`define RMSC_SM1_VEND_F     5:4
`define RMSC_AFTER_RX_F     3:2
`define RMSC_SM1_LOW_F      1:0
`define RMSC_AUTOCAL_F      5:4
`define RMSC_RD_ZERO        8'h00

`define RMSC_DEV_EXP_RST    3'h4
`define RMSC_DEV_MANT_RST   3'h7
`define RMSC_RX_END_RST     1'h0
`define RMSC_SM2_LOW_RST    4'h7
`define RMSC_SM1_VEND_RST   2'h3
`define RMSC_AFTER_RX_RST   2'h0
`define RMSC_SM1_LOW_RST    2'h0
`define RMSC_AUTOCAL_RST    2'h0

`define RMSC_AFTER_IDLE     2'h0
`define RMSC_AFTER_STAY     2'h3
`define RMSC_CAL_NEVER      2'h0
`define RMSC_CAL_TO_RX      2'h1
`define RMSC_CAL_FROM_RX    2'h2
`define RMSC_CAL_EVERY4     2'h3

`define RMSC_NO_CS_SYMBOLS  4'h8
`define RMSC_OOK_MANT_FIX   3'h0
`define RMSC_EVERY4_LAST    2'h3

`endif

// *** include/rmsc_pkg.sv ***
`include "rmsc_cfg.svh"
package rmsc_pkg;
  typedef logic [`RMSC_ADDR_W-1:0] rmsc_addr_t;
  typedef logic [7:0]              rmsc_byte_t;

  typedef enum logic [1:0] {
    RMSC_IDLE,
    RMSC_RX
  } rmsc_state_e;

  typedef struct packed {
    logic [2:0] devExp;
    logic [2:0] devMant;
    logic       rxEndNoCarrier;
    logic [3:0] sm2Low;
    logic [1:0] sm1Vendor;
    logic [1:0] afterRx;
    logic [1:0] sm1Low;
    logic [1:0] autocal;
    rmsc_byte_t rdData;
  } rmsc_regs_s;

  typedef struct packed {
    rmsc_state_e state;
    logic [3:0]  symCnt;
    logic        csSeen;
    logic [1:0]  autoRetCnt;
    logic        calReq;
    logic [2:0]  demodMant;
  } rmsc_ctl_s;
endpackage

// *** include/rmsc_ctl_if.sv ***
`timescale 1ns/100ps
interface rmsc_ctl_if;
  logic [2:0] devMant;
  logic       rxEndNoCarrier;
  logic [1:0] afterRx;
  logic [1:0] autocal;

  modport regs (output devMant, output rxEndNoCarrier, output afterRx, output autocal);
  modport ctl  (input devMant, input rxEndNoCarrier, input afterRx, input autocal);
endinterface

// *** verilog/rmsc_rx_ctl.sv ***
`timescale 1ns/100ps
`include "rmsc_cfg.svh"
module rmsc_rx_ctl (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  rmsc_ctl_if.ctl   cfg,
  input  wire logic ookMode,
  input  wire logic rxStartStrobe,
  input  wire logic calibrateStrobe,
  input  wire logic packetDone,
  input  wire logic carrierSense,
  input  wire logic symbolTick,
  output logic      rxActive,
  output logic      synthCalReq,
  output logic [2:0] demodDevMant
);
  import rmsc_pkg::*;

  rmsc_ctl_s ctl_reg;
  rmsc_ctl_s ctl_next;
  logic      autoReturn;

  always_comb begin
    ctl_next = ctl_reg;
    autoReturn = 1'h0;
    ctl_next.calReq = calibrateStrobe;
    // on-off keying hides the mantissa from the demodulator
    ctl_next.demodMant = ookMode ? `RMSC_OOK_MANT_FIX : cfg.devMant;
    case (ctl_reg.state)
      RMSC_IDLE: begin
        if (rxStartStrobe) begin
          ctl_next.state = RMSC_RX;
          ctl_next.symCnt = 4'h0;
          ctl_next.csSeen = 1'h0;
          if (cfg.autocal == `RMSC_CAL_TO_RX) begin
            ctl_next.calReq = 1'h1;
          end
        end
      end
      RMSC_RX: begin
        if (carrierSense) begin
          ctl_next.csSeen = 1'h1;
        end
        if (symbolTick && ctl_reg.symCnt != `RMSC_NO_CS_SYMBOLS) begin
          ctl_next.symCnt = ctl_reg.symCnt + 4'h1;
        end
        if (packetDone) begin
          if (cfg.afterRx != `RMSC_AFTER_STAY) begin
            autoReturn = 1'h1;
          end
          ctl_next.symCnt = 4'h0;
          ctl_next.csSeen = 1'h0;
        end else if (cfg.rxEndNoCarrier && ookMode && !ctl_reg.csSeen && !carrierSense
                     && ctl_reg.symCnt == `RMSC_NO_CS_SYMBOLS) begin
          autoReturn = 1'h1;
        end
        if (autoReturn) begin
          ctl_next.state = RMSC_IDLE;
          ctl_next.autoRetCnt = ctl_reg.autoRetCnt + 2'h1;
          if (cfg.autocal == `RMSC_CAL_FROM_RX) begin
            ctl_next.calReq = 1'h1;
          end
          if (cfg.autocal == `RMSC_CAL_EVERY4 && ctl_reg.autoRetCnt == `RMSC_EVERY4_LAST) begin
            ctl_next.calReq = 1'h1;
          end
        end
      end
      default: begin
        ctl_next.state = RMSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctl_reg <= '{state: RMSC_IDLE, symCnt: 4'h0, csSeen: 1'h0, autoRetCnt: 2'h0,
                   calReq: 1'h0, demodMant: `RMSC_DEV_MANT_RST};
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign rxActive     = (ctl_reg.state == RMSC_RX);
  assign synthCalReq  = ctl_reg.calReq;
  assign demodDevMant = ctl_reg.demodMant;
endmodule // rmsc_rx_ctl

// *** verilog/rmsc_cfg_regs.sv ***
`timescale 1ns/100ps
`include "rmsc_cfg.svh"
// Notes on behaviour
// - deviation exponent in bits 6:4, reset 100, host read/write
// - deviation mantissa in bits 2:0, reset 111, used for FSK demodulation
// - under on-off keying the mantissa does not reach the demodulator
// - rx_end_on_no_carrier at bit 4 of cfg_two, reset 0, enables early end
// - with it set and OOK, leave receive if no carrier in 8 symbols
// - cfg_two low nibble resets to 0111 and stays writable
// - cfg_one bits 5:4 reset to 11 and stay writable
// - after_rx_state at cfg_one bits 3:2, reset 00, picks post-packet state
// - after_rx_state 00 idle, 11 stay receive, 01 and 10 reserved
// - synth_autocal_select at cfg_zero bits 5:4, reset 00
// - autocal: 00 strobe only, 01 idle-to-rx, 10 auto return, 11 every fourth
module rmsc_cfg_regs (
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  input  wire rmsc_pkg::rmsc_addr_t regAddr,
  input  wire rmsc_pkg::rmsc_byte_t regWrData,
  input  wire logic                 regWrEn,
  input  wire logic                 regRdEn,
  output rmsc_pkg::rmsc_byte_t      regRdData,
  input  wire logic                 ookMode,
  input  wire logic                 rxStartStrobe,
  input  wire logic                 calibrateStrobe,
  input  wire logic                 packetDone,
  input  wire logic                 carrierSense,
  input  wire logic                 symbolTick,
  output logic                      rxActive,
  output logic                      synthCalReq,
  output logic [2:0]                demodDevExp,
  output logic [2:0]                demodDevMant
);
  import rmsc_pkg::*;

  rmsc_regs_s  regs_reg;
  rmsc_regs_s  regs_next;
  rmsc_ctl_if  ctlBus ();

  always_comb begin
    regs_next = regs_reg;
    if (regWrEn) begin
      if (regAddr == `RMSC_OFS_FREQ_DEV) begin
        regs_next.devExp  = regWrData[`RMSC_DEV_EXP_F];
        regs_next.devMant = regWrData[`RMSC_DEV_MANT_F];
      end else if (regAddr == `RMSC_OFS_SM_TWO) begin
        regs_next.rxEndNoCarrier = regWrData[`RMSC_RX_END_BIT];
        regs_next.sm2Low         = regWrData[`RMSC_SM2_LOW_F];
      end else if (regAddr == `RMSC_OFS_SM_ONE) begin
        regs_next.sm1Vendor = regWrData[`RMSC_SM1_VEND_F];
        regs_next.afterRx   = regWrData[`RMSC_AFTER_RX_F];
        regs_next.sm1Low    = regWrData[`RMSC_SM1_LOW_F];
      end else if (regAddr == `RMSC_OFS_SM_ZERO) begin
        regs_next.autocal = regWrData[`RMSC_AUTOCAL_F];
      end
    end
    if (regRdEn) begin
      // unused positions and unmapped addresses return zero
      regs_next.rdData = `RMSC_RD_ZERO;
      if (regAddr == `RMSC_OFS_FREQ_DEV) begin
        regs_next.rdData[`RMSC_DEV_EXP_F]  = regs_reg.devExp;
        regs_next.rdData[`RMSC_DEV_MANT_F] = regs_reg.devMant;
      end else if (regAddr == `RMSC_OFS_SM_TWO) begin
        regs_next.rdData[`RMSC_RX_END_BIT] = regs_reg.rxEndNoCarrier;
        regs_next.rdData[`RMSC_SM2_LOW_F]  = regs_reg.sm2Low;
      end else if (regAddr == `RMSC_OFS_SM_ONE) begin
        regs_next.rdData[`RMSC_SM1_VEND_F] = regs_reg.sm1Vendor;
        regs_next.rdData[`RMSC_AFTER_RX_F] = regs_reg.afterRx;
        regs_next.rdData[`RMSC_SM1_LOW_F]  = regs_reg.sm1Low;
      end else if (regAddr == `RMSC_OFS_SM_ZERO) begin
        regs_next.rdData[`RMSC_AUTOCAL_F] = regs_reg.autocal;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      regs_reg <= '{devExp: `RMSC_DEV_EXP_RST, devMant: `RMSC_DEV_MANT_RST,
                    rxEndNoCarrier: `RMSC_RX_END_RST, sm2Low: `RMSC_SM2_LOW_RST,
                    sm1Vendor: `RMSC_SM1_VEND_RST, afterRx: `RMSC_AFTER_RX_RST,
                    sm1Low: `RMSC_SM1_LOW_RST, autocal: `RMSC_AUTOCAL_RST,
                    rdData: `RMSC_RD_ZERO};
    end else begin
      regs_reg <= regs_next;
    end
  end

  assign ctlBus.devMant        = regs_reg.devMant;
  assign ctlBus.rxEndNoCarrier = regs_reg.rxEndNoCarrier;
  assign ctlBus.afterRx        = regs_reg.afterRx;
  assign ctlBus.autocal        = regs_reg.autocal;

  assign regRdData   = regs_reg.rdData;
  assign demodDevExp = regs_reg.devExp;

  rmsc_rx_ctl u_rx_ctl (
    .clk_sys         (clk_sys),
    .arst_n          (arst_n),
    .cfg             (ctlBus.ctl),
    .ookMode         (ookMode),
    .rxStartStrobe   (rxStartStrobe),
    .calibrateStrobe (calibrateStrobe),
    .packetDone      (packetDone),
    .carrierSense    (carrierSense),
    .symbolTick      (symbolTick),
    .rxActive        (rxActive),
    .synthCalReq     (synthCalReq),
    .demodDevMant    (demodDevMant)
  );
endmodule // rmsc_cfg_regs

// *** tb/rmsc_cfg_regs_sva.sv ***
`timescale 1ns/100ps
module rmsc_cfg_regs_sva
  import rmsc_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire rmsc_addr_t regAddr,
  input wire rmsc_byte_t regWrData,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire rmsc_byte_t regRdData,
  input wire logic       ookMode,
  input wire logic       rxStartStrobe,
  input wire logic       calibrateStrobe,
  input wire logic       packetDone,
  input wire logic       rxActive,
  input wire logic       synthCalReq,
  input wire logic [2:0] demodDevExp,
  input wire logic [2:0] demodDevMant
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  chk_unmapped_zero: assert property (regRdEn && (regAddr < 6'h15 || regAddr > 6'h18)
    |=> regRdData == 8'h00) else $error("unmapped read not zero");
  chk_rd_gap: assert property (regRdEn && regAddr == 6'h15 |=> !regRdData[3])
    else $error("unused bit three set");
  chk_top_bit: assert property (regRdEn |=> !regRdData[7])
    else $error("unused bit seven set");
  chk_exp_write: assert property (regWrEn && regAddr == 6'h15 && regWrData[6:4] == 3'h2
    |=> demodDevExp == 3'h2) else $error("exponent write lost");
  chk_exp_hold: assert property (!(regWrEn && regAddr == 6'h15) |=> $stable(demodDevExp))
    else $error("exponent moved without write");
  chk_ook_mant: assert property (ookMode |=> demodDevMant == 3'h0)
    else $error("mantissa reaches demodulator under ook");
  chk_rx_start: assert property (!rxActive && rxStartStrobe |=> rxActive)
    else $error("receive not entered");
  chk_rx_stay: assert property (rxActive && !ookMode && !packetDone |=> rxActive)
    else $error("receive left without cause");
  chk_cal_manual: assert property (calibrateStrobe |=> synthCalReq)
    else $error("manual calibration missing");
  cover property ($fell(rxActive));
  cover property (synthCalReq);
  cover property (regRdEn && regAddr == 6'h3f);
endmodule // rmsc_cfg_regs_sva

bind rmsc_cfg_regs rmsc_cfg_regs_sva u_rmsc_cfg_regs_sva (.clk_sys, .arst_n, .regAddr,
  .regWrData, .regWrEn, .regRdEn, .regRdData, .ookMode, .rxStartStrobe, .calibrateStrobe,
  .packetDone, .rxActive, .synthCalReq, .demodDevExp, .demodDevMant);

// *** tb/rmsc_host_model.sv ***
`timescale 1ns/100ps
module rmsc_host_model
  import rmsc_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire rmsc_byte_t     regRdData,
  output rmsc_pkg::rmsc_addr_t regAddr,
  output rmsc_pkg::rmsc_byte_t regWrData,
  output logic                regWrEn,
  output logic                regRdEn
);
  initial {regAddr, regWrData, regWrEn, regRdEn} = '0;
  // reserved after_rx_state codes are never written
  task automatic wr(input rmsc_addr_t a, input rmsc_byte_t d);
    @(negedge clk_sys);
    {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
    @(negedge clk_sys);
    {regWrData, regWrEn} = {~d, 1'b0};
  endtask
  task automatic rd(input rmsc_addr_t a, output rmsc_byte_t d);
    @(negedge clk_sys);
    {regAddr, regRdEn} = {a, 1'b1};
    @(negedge clk_sys);
    regRdEn = 1'b0;
    d = regRdData;
  endtask
endmodule // rmsc_host_model

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import rmsc_pkg::*;
  typedef struct packed {logic w; rmsc_addr_t a; rmsc_byte_t d; rmsc_byte_t e;} rmsc_row_s;
  localparam rmsc_row_s ROWS [10] = '{
    '{1'b0, 6'h15, 8'h00, 8'h47}, '{1'b0, 6'h16, 8'h00, 8'h07}, '{1'b0, 6'h17, 8'h00, 8'h30},
    '{1'b0, 6'h18, 8'h00, 8'h00}, '{1'b0, 6'h3f, 8'h00, 8'h00}, '{1'b1, 6'h15, 8'hff, 8'h77},
    '{1'b1, 6'h16, 8'hff, 8'h1f}, '{1'b1, 6'h17, 8'hff, 8'h3f}, '{1'b1, 6'h18, 8'hff, 8'h30},
    '{1'b1, 6'h14, 8'hff, 8'h00}};
  logic       clk_sys, arst_n, ookMode, rxActive, synthCalReq, regWrEn, regRdEn;
  logic [4:0] ev;
  logic [2:0] demodDevExp, demodDevMant;
  rmsc_addr_t regAddr;
  rmsc_byte_t regWrData, regRdData, rd;
  int         failures, checks;
  rmsc_host_model u_rmsc_host_model (.clk_sys(clk_sys), .regRdData(regRdData),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn));
  rmsc_cfg_regs u_rmsc_cfg_regs (.clk_sys(clk_sys), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .ookMode(ookMode), .rxStartStrobe(ev[4]), .calibrateStrobe(ev[3]), .packetDone(ev[2]),
    .carrierSense(ev[1]), .symbolTick(ev[0]), .rxActive(rxActive), .synthCalReq(synthCalReq),
    .demodDevExp(demodDevExp), .demodDevMant(demodDevMant));
  task automatic cmp(input string n, input rmsc_byte_t e, input rmsc_byte_t s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic pulse(input logic [4:0] m, input int n);
    @(negedge clk_sys);
    ev = m;
    repeat (n) @(negedge clk_sys);
    ev = 5'h00;
  endtask
  task automatic conclude();
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    failures++;
    conclude();
  end
  initial begin
    {arst_n, ookMode, ev} = '0;
    repeat (3) @(negedge clk_sys);
    arst_n = 1'b1;
    cmp("dev_rst", 8'h47, {1'b0, demodDevExp, 1'b0, demodDevMant});
    foreach (ROWS[i]) begin
      if (ROWS[i].w) u_rmsc_host_model.wr(ROWS[i].a, ROWS[i].d);
      u_rmsc_host_model.rd(ROWS[i].a, rd);
      cmp("reg", ROWS[i].e, rd);
    end
    u_rmsc_host_model.wr(6'h15, 8'h25);
    ookMode = 1'b1;
    repeat (2) @(negedge clk_sys);
    cmp("ook_dev", 8'h20, {1'b0, demodDevExp, 1'b0, demodDevMant});
    u_rmsc_host_model.wr(6'h18, 8'h10);
    pulse(5'h10, 1);
    cmp("cal_to_rx", 8'h03, {6'h0, rxActive, synthCalReq});
    pulse(5'h01, 7);
    cmp("rx_wait", 8'h01, {7'h0, rxActive});
    pulse(5'h01, 1);
    @(negedge clk_sys);
    cmp("rx_timeout", 8'h00, {7'h0, rxActive});
    ookMode = 1'b0;
    @(negedge clk_sys);
    cmp("fsk_mant", 8'h05, {5'h0, demodDevMant});
    pulse(5'h10, 1);
    pulse(5'h04, 1);
    cmp("stay_rx", 8'h01, {7'h0, rxActive});
    u_rmsc_host_model.wr(6'h17, 8'h30);
    u_rmsc_host_model.wr(6'h18, 8'h20);
    pulse(5'h04, 1);
    cmp("to_idle", 8'h01, {6'h0, rxActive, synthCalReq});
    pulse(5'h08, 1);
    cmp("cal_manual", 8'h01, {7'h0, synthCalReq});
    arst_n = 1'b0;
    @(negedge clk_sys);
    arst_n = 1'b1;
    u_rmsc_host_model.rd(6'h15, rd);
    cmp("dev_rerst", 8'h47, rd);
    u_rmsc_host_model.wr(6'h18, 8'h30);
    for (int k = 0; k < 4; k++) begin
      pulse(5'h10, 1);
      pulse(5'h04, 1);
      cmp("cal_every4", {7'h0, k == 3}, {6'h0, rxActive, synthCalReq});
    end
    u_rmsc_host_model.wr(6'h16, 8'h17);
    ookMode = 1'b1;
    pulse(5'h10, 1);
    pulse(5'h02, 1);
    pulse(5'h01, 8);
    @(negedge clk_sys);
    cmp("cs_hold", 8'h01, {7'h0, rxActive});
    pulse(5'h04, 1);
    u_rmsc_host_model.wr(6'h16, 8'h07);
    pulse(5'h10, 1);
    pulse(5'h01, 8);
    @(negedge clk_sys);
    cmp("no_early_end", 8'h01, {7'h0, rxActive});
    conclude();
  end
endmodule // tb_top
